// [core/sclk_regs.svh]
// register offsets, field positions, reset values and timing counts of the clock stability control
`ifndef SCLK_REGS_SVH
`define SCLK_REGS_SVH
// register indices (printed offsets are not all multiples of four, so byte address is index times four)
`define SCLK_IDX_SYNTH_CTRL     12'h100
`define SCLK_IDX_PERIOD         12'h103
`define SCLK_IDX_STAB_DUR       12'h106
`define SCLK_IDX_IRQ_MASK       12'h209
`define SCLK_IDX_CAL_CTRL       12'ha02
`define SCLK_IDX_STATUS         12'hd01
`define SCLK_IDX_IRQ_MON        12'hd02
`define SCLK_IDX_IRQ_STAT       12'hd03
`define SCLK_ADDR_W             14
// synth control fields
`define SCLK_BIT_EXT_FILT       7
`define SCLK_BIT_LD_OFF         2
`define SCLK_BIT_SYNTH_OFF      3
`define SCLK_BIT_CAL            0
// status fields
`define SCLK_BIT_STABLE         4
`define SCLK_BIT_CAL_BUSY       1
`define SCLK_BIT_LOCK           0
// widths and resets
`define SCLK_PERIOD_W           21
`define SCLK_DUR_W              20
// a 21-bit fs period cannot hold 10 ns; default is 1 ns, software must program the real period
`define SCLK_PERIOD_RST         21'h0f4240
`define SCLK_DUR_RST            20'h00000
`define SCLK_CTRL_RST           8'h00
// one millisecond in femtoseconds
`define SCLK_MS_FS              50'h0e8d4a51000
`define SCLK_CAL_CYCLES         16'h0400
`define SCLK_LOCK_BASE          11'h080
`endif

// [core/sclk_pkg.sv]
// types of the clock stability control
package sclk_pkg;
  // calibration sequence states
  typedef enum logic [1:0] {
    CAL_IDLE  = 2'b00,
    CAL_ARMED = 2'b01,
    CAL_AMPL  = 2'b10,
    CAL_FREQ  = 2'b11
  } sclk_cal_type;
  // stability timer states
  typedef enum logic [1:0] {
    TMR_WAIT  = 2'b00,
    TMR_COUNT = 2'b01,
    TMR_DONE  = 2'b10
  } sclk_tmr_type;
  // interrupt event bits
  typedef struct packed {
    logic stable;
    logic calDone;
    logic lock;
  } sclk_evt_type;
endpackage

// [core/sclk_stability_ctrl.sv]
// system clock stability control with axi4-lite register slave
//
// How it works
// [RULE1] external loop filter bit bypasses internal filter
// [RULE2] hold 21-bit clock period in femtoseconds
// [RULE3] stability timer duration, 20 bits, milliseconds
// [RULE4] zero duration times out at once
// [RULE5] enabled synth: count starts at lock
// [RULE6] disabled synth: count starts at disable
// [RULE7] timed-out state readable and driven out
// [RULE8] software writes duration before enable change
// [RULE9] calibrate on set then clear of bit
// [RULE10] calibration progress readable as status
// [RULE11] monitor shows calibration only when unmasked
// [RULE12] calibration done and lock start countdown
// [RULE13] reference monitors disabled until stable
// [RULE14] lock after 128..1024 consecutive in-phase samples
// [RULE15] software zeroes duration when detector off
// [RULE16] millisecond tick from accumulated clock period
//
// The AXI4-Lite slave port was chosen for this implementation.
`include "sclk_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module sclk_stability_ctrl (
  input  wire logic                       clk,
  input  wire logic                       nrst,
  // axi4-lite slave
  input  wire logic [`SCLK_ADDR_W-1:0]    awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  input  wire logic [`SCLK_ADDR_W-1:0]    araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  // synthesizer side
  input  wire logic                       phaseInPhase,
  output logic                            extFilterSel,
  output logic                            synthEnable,
  output logic                            calRun,
  output logic                            clockStable,
  output logic                            refMonitorEnable,
  output logic [`SCLK_PERIOD_W-1:0]       periodOut,
  output logic                            irq
);

  // ****************************************
  // registers
  // ****************************************
  logic [7:0]                  ctrl_r;       // synth control
  logic [`SCLK_PERIOD_W-1:0]   period_r;     // clock period, fs
  logic [`SCLK_DUR_W-1:0]      dur_r;        // stability duration, ms
  logic                        calBit_r;     // calibrate control bit
  logic [2:0]                  irqMask_r;    // interrupt mask
  sclk_pkg::sclk_evt_type      irqStat_r;    // sticky events
  logic                        inPhase1_r;   // sync stage one
  logic                        inPhase2_r;   // sync stage two
  logic [10:0]                 lockCnt_r;    // consecutive in-phase count
  logic                        lock_r;       // lock detected
  sclk_pkg::sclk_cal_type      calState_r;   // calibration state
  logic [15:0]                 calCnt_r;     // calibration step count
  sclk_pkg::sclk_tmr_type      tmrState_r;   // timer state
  logic [49:0]                 fsAcc_r;      // femtosecond accumulator
  logic [`SCLK_DUR_W-1:0]      msCnt_r;      // elapsed milliseconds
  logic                        synthOffPrev_r; // previous disable bit
  logic                        lockPrev_r;   // previous lock
  logic                        calPrev_r;    // previous cal busy

  // ****************************************
  // bus handshake
  // ****************************************
  logic                        awHave_r;     // address held
  logic                        wHave_r;      // data held
  logic [`SCLK_ADDR_W-1:0]     awAddr_r;     // held write address
  logic [31:0]                 wData_r;      // held write data
  logic [3:0]                  wStrb_r;      // held strobes
  logic                        wrGo;         // write commits now
  logic [11:0]                 wIdx;         // write register index
  logic [11:0]                 rIdx;         // read register index
  logic                        wrMapped;     // write hits a register
  logic [31:0]                 rdVal;        // read mux
  logic                        rdMapped;     // read hits a register
  logic                        calBusy;      // calibration under way
  logic                        synthOff;     // synth disabled
  logic                        tick;         // one-millisecond pulse
  sclk_pkg::sclk_evt_type      evt;          // event pulses
  logic [2:0]                  irqMon;       // masked status

  assign wrGo     = awHave_r && wHave_r && !bvalid;
  assign wIdx     = awAddr_r[13:2];
  assign rIdx     = araddr[13:2];
  assign calBusy  = (calState_r == sclk_pkg::CAL_AMPL) || (calState_r == sclk_pkg::CAL_FREQ);
  assign synthOff = ctrl_r[`SCLK_BIT_SYNTH_OFF];
  assign irqMon   = irqStat_r & irqMask_r;

  // write address and data taken in either order
  always_ff @(posedge clk) begin
    if (!nrst) begin
      awHave_r <= 1'b0;
      wHave_r  <= 1'b0;
      awAddr_r <= '0;
      wData_r  <= '0;
      wStrb_r  <= '0;
      awready  <= 1'b0;
      wready   <= 1'b0;
    end else begin
      awready <= !awHave_r && !awready && awvalid;
      wready  <= !wHave_r && !wready && wvalid;
      if (awready && awvalid) begin
        awHave_r <= 1'b1;
        awAddr_r <= awaddr;
      end else if (wrGo) begin
        awHave_r <= 1'b0;
      end
      if (wready && wvalid) begin
        wHave_r <= 1'b1;
        wData_r <= wdata;
        wStrb_r <= wstrb;
      end else if (wrGo) begin
        wHave_r <= 1'b0;
      end
    end
  end

  // write decode
  always_comb begin
    case (wIdx)
      `SCLK_IDX_SYNTH_CTRL, `SCLK_IDX_PERIOD, `SCLK_IDX_STAB_DUR, `SCLK_IDX_IRQ_MASK,
      `SCLK_IDX_CAL_CTRL, `SCLK_IDX_IRQ_STAT: wrMapped = 1'b1;
      default: wrMapped = 1'b0;
    endcase
  end

  // write response, slverr on unmapped
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bvalid <= 1'b0;
      bresp  <= 2'b00;
    end else if (wrGo) begin
      bvalid <= 1'b1;
      bresp  <= wrMapped ? 2'b00 : 2'b10;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // register writes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_r    <= `SCLK_CTRL_RST;
      period_r  <= `SCLK_PERIOD_RST;
      dur_r     <= `SCLK_DUR_RST;
      calBit_r  <= 1'b0;
      irqMask_r <= 3'h0;
    end else if (wrGo) begin
      case (wIdx)
        `SCLK_IDX_SYNTH_CTRL: if (wStrb_r[0]) ctrl_r <= wData_r[7:0];
        // [RULE2] period held
        `SCLK_IDX_PERIOD: begin
          if (wStrb_r[0]) period_r[7:0]   <= wData_r[7:0];
          if (wStrb_r[1]) period_r[15:8]  <= wData_r[15:8];
          if (wStrb_r[2]) period_r[20:16] <= wData_r[20:16];
        end
        // [RULE3] duration held
        `SCLK_IDX_STAB_DUR: begin
          if (wStrb_r[0]) dur_r[7:0]   <= wData_r[7:0];
          if (wStrb_r[1]) dur_r[15:8]  <= wData_r[15:8];
          if (wStrb_r[2]) dur_r[19:16] <= wData_r[19:16];
        end
        `SCLK_IDX_IRQ_MASK: if (wStrb_r[0]) irqMask_r <= wData_r[2:0];
        `SCLK_IDX_CAL_CTRL: if (wStrb_r[0]) calBit_r <= wData_r[`SCLK_BIT_CAL];
        default: ;
      endcase
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  always_comb begin
    rdMapped = 1'b1;
    rdVal    = 32'h00000000;
    case (rIdx)
      `SCLK_IDX_SYNTH_CTRL: rdVal = {24'h000000, ctrl_r};
      `SCLK_IDX_PERIOD:     rdVal = {11'h000, period_r};
      `SCLK_IDX_STAB_DUR:   rdVal = {12'h000, dur_r};
      `SCLK_IDX_IRQ_MASK:   rdVal = {29'h00000000, irqMask_r};
      `SCLK_IDX_CAL_CTRL:   rdVal = {31'h00000000, calBit_r};
      // [RULE7] timed-out readable
      // [RULE10] calibration progress
      `SCLK_IDX_STATUS:     rdVal = {27'h0000000, (tmrState_r == sclk_pkg::TMR_DONE), 2'b00, calBusy, lock_r};
      // [RULE11] masked monitor view
      `SCLK_IDX_IRQ_MON:    rdVal = {27'h0000000, irqMon[2], 2'b00, irqMon[1], irqMon[0]};
      `SCLK_IDX_IRQ_STAT:   rdVal = {29'h00000000, irqStat_r};
      default:              rdMapped = 1'b0;
    endcase
  end

  // read answer one cycle after address taken
  always_ff @(posedge clk) begin
    if (!nrst) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= 2'b00;
    end else begin
      arready <= arvalid && !arready && !rvalid;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata  <= rdVal;
        rresp  <= rdMapped ? 2'b00 : 2'b10;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // lock detector
  // ****************************************
  // in-phase sample from the synth domain, two flops
  always_ff @(posedge clk) begin
    if (!nrst) begin
      inPhase1_r <= 1'b0;
      inPhase2_r <= 1'b0;
    end else begin
      inPhase1_r <= phaseInPhase;
      inPhase2_r <= inPhase1_r;
    end
  end

  // [RULE14] consecutive sample count
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lockCnt_r <= 11'h000;
      lock_r    <= 1'b0;
    end else if (ctrl_r[`SCLK_BIT_LD_OFF] || synthOff || calBusy || !inPhase2_r) begin
      lockCnt_r <= 11'h000;
      lock_r    <= ctrl_r[`SCLK_BIT_LD_OFF] && !synthOff && !calBusy;
    end else if (lockCnt_r >= (`SCLK_LOCK_BASE << ctrl_r[1:0]) - 11'h001) begin
      lock_r <= 1'b1;
    end else begin
      lockCnt_r <= lockCnt_r + 11'h001;
    end
  end

  // ****************************************
  // calibration
  // ****************************************
  // [RULE9] set then clear starts sequence
  always_ff @(posedge clk) begin
    if (!nrst) begin
      calState_r <= sclk_pkg::CAL_IDLE;
      calCnt_r   <= 16'h0000;
    end else begin
      unique case (calState_r)
        sclk_pkg::CAL_IDLE:  if (calBit_r) calState_r <= sclk_pkg::CAL_ARMED;
        sclk_pkg::CAL_ARMED: if (!calBit_r) begin
          calState_r <= sclk_pkg::CAL_AMPL;
          calCnt_r   <= 16'h0000;
        end
        sclk_pkg::CAL_AMPL: begin
          calCnt_r <= calCnt_r + 16'h0001;
          if (calCnt_r == `SCLK_CAL_CYCLES - 16'h0001) begin
            calState_r <= sclk_pkg::CAL_FREQ;
            calCnt_r   <= 16'h0000;
          end
        end
        sclk_pkg::CAL_FREQ: begin
          calCnt_r <= calCnt_r + 16'h0001;
          if (calCnt_r == `SCLK_CAL_CYCLES - 16'h0001) calState_r <= sclk_pkg::CAL_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // stability timer
  // ****************************************
  // [RULE16] fs accumulation gives ms tick
  assign tick = (fsAcc_r + {29'h0, period_r}) >= `SCLK_MS_FS;
  always_ff @(posedge clk) begin
    if (!nrst || tmrState_r != sclk_pkg::TMR_COUNT) begin
      fsAcc_r <= 50'h0;
    end else if (tick) begin
      fsAcc_r <= fsAcc_r + {29'h0, period_r} - `SCLK_MS_FS;
    end else begin
      fsAcc_r <= fsAcc_r + {29'h0, period_r};
    end
  end

  // timer sequence
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tmrState_r     <= sclk_pkg::TMR_WAIT;
      msCnt_r        <= '0;
      synthOffPrev_r <= 1'b0;
    end else begin
      synthOffPrev_r <= synthOff;
      // restart on a change of synth enable or a new calibration
      if (synthOff != synthOffPrev_r || calBusy) begin
        tmrState_r <= sclk_pkg::TMR_WAIT;
        msCnt_r    <= '0;
      end else begin
        unique case (tmrState_r)
          sclk_pkg::TMR_WAIT: begin
            msCnt_r <= '0;
            // [RULE4] zero duration done at once
            if (dur_r == '0) tmrState_r <= sclk_pkg::TMR_DONE;
            // [RULE6] disabled synth ignores lock
            else if (synthOff) tmrState_r <= sclk_pkg::TMR_COUNT;
            // [RULE5] [RULE12] count from lock
            else if (lock_r) tmrState_r <= sclk_pkg::TMR_COUNT;
          end
          sclk_pkg::TMR_COUNT: begin
            if (!synthOff && !lock_r) tmrState_r <= sclk_pkg::TMR_WAIT;
            else if (tick) begin
              msCnt_r <= msCnt_r + 20'h00001;
              if (msCnt_r + 20'h00001 >= dur_r) tmrState_r <= sclk_pkg::TMR_DONE;
            end
          end
          sclk_pkg::TMR_DONE: if (!synthOff && !lock_r && dur_r != '0) tmrState_r <= sclk_pkg::TMR_WAIT;
          default: tmrState_r <= sclk_pkg::TMR_WAIT;
        endcase
      end
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lockPrev_r <= 1'b0;
      calPrev_r  <= 1'b0;
    end else begin
      lockPrev_r <= lock_r;
      calPrev_r  <= calBusy;
    end
  end
  assign evt.lock    = lock_r && !lockPrev_r;
  assign evt.calDone = calPrev_r && !calBusy;
  assign evt.stable  = (tmrState_r == sclk_pkg::TMR_DONE) && !clockStable;

  // sticky bits, write one clears, set wins
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irqStat_r <= '0;
    end else begin
      irqStat_r <= (irqStat_r & ~((wrGo && wIdx == `SCLK_IDX_IRQ_STAT && wStrb_r[0]) ? wData_r[2:0] : 3'h0)) | evt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      extFilterSel     <= 1'b0;
      synthEnable      <= 1'b1;
      calRun           <= 1'b0;
      clockStable      <= 1'b0;
      refMonitorEnable <= 1'b0;
      periodOut        <= `SCLK_PERIOD_RST;
      irq              <= 1'b0;
    end else begin
      // [RULE1] filter select
      extFilterSel     <= ctrl_r[`SCLK_BIT_EXT_FILT];
      synthEnable      <= !synthOff;
      calRun           <= calBusy;
      // [RULE7] stable routed out
      clockStable      <= (tmrState_r == sclk_pkg::TMR_DONE);
      // [RULE13] monitors gated by stable
      refMonitorEnable <= (tmrState_r == sclk_pkg::TMR_DONE);
      periodOut        <= period_r;
      irq              <= |irqMon;
    end
  end

endmodule // sclk_stability_ctrl
`default_nettype wire

// [tb/sclk_props.sv]
// port checker of the clock stability control
`timescale 1ns/1ns
`default_nettype none
module sclk_props (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        bvalid,
  input wire logic [1:0]  bresp,
  input wire logic        calRun,
  input wire logic        clockStable,
  input wire logic        refMonitorEnable,
  input wire logic        extFilterSel,
  input wire logic [20:0] periodOut,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [11:0] calCnt; // cycles that calibration has run
  // count calibration length
  always_ff @(posedge clk) begin
    if (!nrst) calCnt <= 12'h000;
    else calCnt <= calRun ? calCnt + 12'h001 : 12'h000;
  end
  a_ref_gate: assert property (refMonitorEnable == clockStable)
    else $error("monitor enable differs from stable");
  a_cal_len: assert property ($fell(calRun) |-> calCnt == 12'h800)
    else $error("calibration length wrong");
  a_zero_dur: assert property ($rose(nrst) |-> ##[0:20] clockStable)
    else $error("zero duration did not time out");
  a_cfg_write: assert property ($changed({extFilterSel, periodOut}) |->
    ($past(wvalid) || $past(wvalid, 2) || $past(wvalid, 3) || $past(wvalid, 4)))
    else $error("setting changed without a write");
  a_aw_pulse: assert property (awready |=> !awready)
    else $error("awready not a pulse");
  a_r_latency: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_r_single: assert property (rvalid && rready |=> !rvalid)
    else $error("read answer repeated");
  a_resp_legal: assert property (bvalid |-> bresp inside {2'b00, 2'b10})
    else $error("illegal write response");
  c_cal: cover property ($rose(calRun));
  c_irq: cover property ($rose(irq));
  c_err: cover property (bvalid && bresp == 2'b10);
endmodule // sclk_props
bind sclk_stability_ctrl sclk_props chk_u (.clk, .nrst, .awready, .wvalid, .arvalid, .arready, .rvalid,
  .rready, .bvalid, .bresp, .calRun, .clockStable, .refMonitorEnable, .extFilterSel, .periodOut, .irq);
`default_nettype wire

// [tb/sclk_synth_model.sv]
// phase detector samples of the system clock synthesizer
`timescale 1ns/1ns
`default_nettype none
module sclk_synth_model (
  input  wire logic clk,
  input  wire logic synthEnable,
  input  wire logic calRun,
  input  wire logic inLock,
  output logic      phaseInPhase
);
  logic flip = 1'b0; // chatter while acquiring
  // out of phase every other sample
  always_ff @(posedge clk) flip <= ~flip;
  assign phaseInPhase = (synthEnable && !calRun && inLock) ? 1'b1 : flip;
endmodule // sclk_synth_model
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench of the clock stability control
`include "sclk_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam logic [11:0] CT = `SCLK_IDX_SYNTH_CTRL, PER = `SCLK_IDX_PERIOD, DUR = `SCLK_IDX_STAB_DUR,
    MSK = `SCLK_IDX_IRQ_MASK, CAL = `SCLK_IDX_CAL_CTRL, ST = `SCLK_IDX_STATUS, MON = `SCLK_IDX_IRQ_MON,
    STK = `SCLK_IDX_IRQ_STAT;
  logic        clk = 1'b0, nrst = 1'b0, inLock = 1'b0;
  logic [13:0] awaddr = 14'h0000, araddr = 14'h0000;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h00000000, rdata, rdVal;
  logic [3:0]  wstrb = 4'hf;
  logic        awready, wready, bvalid, arready, rvalid, phaseInPhase, extFilterSel, synthEnable;
  logic        calRun, clockStable, refMonitorEnable, irq;
  logic [1:0]  bresp, rresp, resp;
  logic [20:0] periodOut;
  int          failures = 0, cmp_count = 0;
  sclk_stability_ctrl dut_u (.clk, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .phaseInPhase,
    .extFilterSel, .synthEnable, .calRun, .clockStable, .refMonitorEnable, .periodOut, .irq);
  sclk_synth_model syn_u (.clk, .synthEnable, .calRun, .inLock, .phaseInPhase);
  always #5 clk = ~clk;
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // axi4-lite write, valids held until each is taken
  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    logic a, w;
    int n;
    a = 1'b1;
    w = 1'b1;
    n = 0;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while ((a || w) && n < 50) begin
      @(posedge clk);
      n++;
      if (awready) begin a = 1'b0; awvalid <= 1'b0; end
      if (wready) begin w = 1'b0; wvalid <= 1'b0; end
    end
    while (!bvalid && n < 50) begin @(posedge clk); n++; end
    resp = bresp;
    bready <= 1'b0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask
  // axi4-lite read into rdVal
  task automatic rd(input logic [11:0] idx);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin @(posedge clk); n++; end while (!arready && n < 50);
    arvalid <= 1'b0;
    while (!rvalid && n < 50) begin @(posedge clk); n++; end
    rdVal = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask
  // write then read back
  task automatic wrc(input logic [11:0] idx, input logic [31:0] d, input logic [31:0] e);
    wr(idx, d);
    rd(idx);
    chk(rdVal, e);
  endtask
  // read until masked value matches, bounded
  task automatic poll(input logic [11:0] idx, input logic [31:0] m, input logic [31:0] e);
    rd(idx);
    for (int k = 0; k < 1000 && (rdVal & m) !== e; k++) rd(idx);
    chk(rdVal & m, e);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    results();
  end
  // **************************
  // main sequence
  // **************************
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    poll(ST, 32'h10, 32'h10);
    chk({31'h0, refMonitorEnable}, 32'h1);
    chk({31'h0, synthEnable}, 32'h1);
    chk({11'h0, periodOut}, {11'h0, `SCLK_PERIOD_RST});
    rd(CT);
    chk(rdVal, 32'h0);
    rd(DUR);
    chk(rdVal, 32'h0);
    wr(DUR, 32'h1);
    wr(CT, 32'h8);
    repeat (20) @(posedge clk);
    chk({30'h0, synthEnable, clockStable}, 32'h0);
    wr(CT, 32'h0);
    repeat (300) @(posedge clk);
    chk({31'h0, clockStable}, 32'h0);
    for (int n = 0; n < 4; n++) begin
      inLock <= 1'b0;
      wr(CT, n);
      poll(ST, 32'h1, 32'h0);
      inLock <= 1'b1;
      repeat ((128 << n) - 40) @(posedge clk);
      rd(ST);
      chk(rdVal & 32'h1, 32'h0);
      poll(ST, 32'h1, 32'h1);
    end
    chk({31'h0, clockStable}, 32'h0);
    wr(DUR, 32'h0);
    wr(CT, 32'hc);
    poll(ST, 32'h10, 32'h10);
    wrc(CT, 32'h80, 32'h80);
    chk({31'h0, extFilterSel}, 32'h1);
    wrc(CT, 32'h0, 32'h0);
    chk({31'h0, extFilterSel}, 32'h0);
    wrc(PER, 32'hffffffff, 32'h1fffff);
    wrc(PER, 32'h0abcde, 32'h0abcde);
    chk({11'h0, periodOut}, 32'h0abcde);
    wrc(DUR, 32'hffffffff, 32'hfffff);
    wrc(DUR, 32'h0, 32'h0);
    rd(12'h3ff);
    chk({resp, rdVal[29:0]}, 32'h80000000);
    wr(12'h3ff, 32'h1);
    chk({30'h0, resp}, 32'h2);
    wr(MSK, 32'h0);
    wr(STK, 32'h7);
    wr(CAL, 32'h1);
    repeat (5) @(posedge clk);
    chk({31'h0, calRun}, 32'h0);
    wr(CAL, 32'h0);
    poll(ST, 32'h2, 32'h2);
    chk({31'h0, calRun}, 32'h1);
    poll(ST, 32'h2, 32'h0);
    rd(MON);
    chk(rdVal & 32'h2, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(MSK, 32'h2);
    rd(MON);
    chk(rdVal & 32'h2, 32'h2);
    chk({31'h0, irq}, 32'h1);
    wr(STK, 32'h2);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    poll(ST, 32'h11, 32'h11);
    results();
  end
endmodule // tb_top
`default_nettype wire
